// >>> cab_exec_consts.vh
// constants shared by the alu, flow and execution core files
`ifndef CAB_EXEC_CONSTS_VH
`define CAB_EXEC_CONSTS_VH

// ----------------------------------------------------------------
// widths and fields
// ----------------------------------------------------------------
`define CAB_OP_W 6
`define CAB_PC_W 16
`define CAB_SEL_MSB 10
`define CAB_SEL_LSB 8
`define CAB_K8_MSB 7
`define CAB_K6_MSB 5
`define CAB_K7_MSB 6
`define CAB_K7_SIGN 6
`define CAB_K12_SIGN 11
`define CAB_ZPTR_LO 5'h1E
`define CAB_ZPTR_HI 5'h1F
`define CAB_NREGS 32

// ----------------------------------------------------------------
// operation codes
// ----------------------------------------------------------------
`define CAB_OP_IDLE 6'h00
`define CAB_OP_SUM 6'h01
`define CAB_OP_SUMC 6'h02
`define CAB_OP_WSUM 6'h03
`define CAB_OP_DIFF 6'h04
`define CAB_OP_DIFFI 6'h05
`define CAB_OP_BDIFF 6'h06
`define CAB_OP_BDIFFI 6'h07
`define CAB_OP_WDIFF 6'h08
`define CAB_OP_CONJ 6'h09
`define CAB_OP_CONJI 6'h0A
`define CAB_OP_DISJ 6'h0B
`define CAB_OP_DISJI 6'h0C
`define CAB_OP_XDISJ 6'h0D
`define CAB_OP_INV 6'h0E
`define CAB_OP_NEGATE 6'h0F
`define CAB_OP_SETM 6'h10
`define CAB_OP_CLRM 6'h11
`define CAB_OP_INCR 6'h12
`define CAB_OP_DECR 6'h13
`define CAB_OP_ZSCHK 6'h14
`define CAB_OP_ZREG 6'h15
`define CAB_OP_ONES 6'h16
`define CAB_OP_RGOTO 6'h17
`define CAB_OP_PGOTO 6'h18
`define CAB_OP_RINVK 6'h19
`define CAB_OP_PINVK 6'h1A
`define CAB_OP_RBACK 6'h1B
`define CAB_OP_IBACK 6'h1C
`define CAB_OP_EQSKIP 6'h1D
`define CAB_OP_CMPR 6'h1E
`define CAB_OP_CMPB 6'h1F
`define CAB_OP_CMPI 6'h20
`define CAB_OP_SKRL 6'h21
`define CAB_OP_SKRH 6'h22
`define CAB_OP_SKIL 6'h23
`define CAB_OP_SKIH 6'h24
`define CAB_OP_BRFH 6'h25
`define CAB_OP_BRFL 6'h26
`define CAB_OP_BRCH 6'h27
`define CAB_OP_BRCL 6'h28
`define CAB_OP_BRUL 6'h29
`define CAB_OP_BRUG 6'h2A

// ----------------------------------------------------------------
// status flag positions and update masks
// ----------------------------------------------------------------
`define CAB_FL_C 0
`define CAB_FL_Z 1
`define CAB_FL_N 2
`define CAB_FL_V 3
`define CAB_FL_S 4
`define CAB_FL_H 5
`define CAB_FL_T 6
`define CAB_FL_I 7
`define CAB_MASK_NONE 8'h00
`define CAB_MASK_ARITH 8'h2F
`define CAB_MASK_LOGIC 8'h0E
`define CAB_MASK_INV 8'h0F
`define CAB_MASK_WORD 8'h1F
`define CAB_MASK_GIE 8'h80

// ----------------------------------------------------------------
// alu modes, constants, cycle counts
// ----------------------------------------------------------------
`define CAB_ALU_ADD 3'h0
`define CAB_ALU_SUB 3'h1
`define CAB_ALU_AND 3'h2
`define CAB_ALU_OR 3'h3
`define CAB_ALU_XOR 3'h4
`define CAB_BYTE_ALL 8'hFF
`define CAB_BYTE_NONE 8'h00
`define CAB_BYTE_ONE 8'h01
`define CAB_CYC_1 3'h1
`define CAB_CYC_2 3'h2
`define CAB_CYC_3 3'h3
`define CAB_CYC_4 3'h4
`define CAB_PC_RESET 16'h0000

`endif

// >>> cab_byte_alu.v
// byte adder, subtractor and logic unit with carry, half-carry, overflow
`timescale 1ns/1ps
`include "cab_exec_consts.vh"

module cab_byte_alu (
  input wire [7:0] a_i,
  input wire [7:0] b_i,
  input wire cin_i,
  input wire [2:0] mode_i,
  output reg [7:0] res_o,
  output reg c_o,
  output reg h_o,
  output reg v_o
);

  wire [8:0] add_w;
  wire [4:0] add_h_w;
  wire [8:0] sub_w;
  wire [4:0] sub_h_w;

  assign add_w = {1'b0, a_i} + {1'b0, b_i} + {8'h00, cin_i};
  assign add_h_w = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, cin_i};
  assign sub_w = {1'b0, a_i} - {1'b0, b_i} - {8'h00, cin_i};
  assign sub_h_w = {1'b0, a_i[3:0]} - {1'b0, b_i[3:0]} - {4'h0, cin_i};

  always @*
  begin
    res_o = `CAB_BYTE_NONE;
    c_o = 1'b0;
    h_o = 1'b0;
    v_o = 1'b0;
    case (mode_i)
      `CAB_ALU_ADD:
      begin
        res_o = add_w[7:0];
        c_o = add_w[8];
        h_o = add_h_w[4];
        v_o = (a_i[7] == b_i[7]) && (add_w[7] != a_i[7]);
      end
      `CAB_ALU_SUB:
      begin
        res_o = sub_w[7:0];
        c_o = sub_w[8];
        h_o = sub_h_w[4];
        v_o = (a_i[7] != b_i[7]) && (sub_w[7] != a_i[7]);
      end
      `CAB_ALU_AND: res_o = a_i & b_i;
      `CAB_ALU_OR: res_o = a_i | b_i;
      `CAB_ALU_XOR: res_o = a_i ^ b_i;
      default: res_o = `CAB_BYTE_NONE;
    endcase
  end

endmodule // cab_byte_alu

// >>> cab_flow_unit.v
// next program counter and cycle count for jumps, calls, returns, skips, branches
`timescale 1ns/1ps
`include "cab_exec_consts.vh"

module cab_flow_unit (
  input wire [5:0] op_i,
  input wire [15:0] pc_i,
  input wire [11:0] imm_i,
  input wire [2:0] sel_i,
  input wire [7:0] rd_val_i,
  input wire [7:0] rr_val_i,
  input wire [7:0] io_val_i,
  input wire [7:0] flags_i,
  input wire [15:0] zptr_i,
  input wire [15:0] stack_pc_i,
  input wire two_word_i,
  output reg [15:0] pc_nxt_o,
  output reg [2:0] cyc_o
);

  wire [15:0] pc_inc_w;
  wire [15:0] rel12_w;
  wire [15:0] rel7_w;
  wire [2:0] skip_len_w;
  reg skip;
  reg take;

  assign pc_inc_w = pc_i + 16'h0001;
  assign rel12_w = {{4{imm_i[`CAB_K12_SIGN]}}, imm_i};
  assign rel7_w = {{9{imm_i[`CAB_K7_SIGN]}}, imm_i[`CAB_K7_MSB:0]};
  assign skip_len_w = two_word_i ? `CAB_CYC_3 : `CAB_CYC_2;

  always @*
  begin
    pc_nxt_o = pc_inc_w;
    cyc_o = `CAB_CYC_1;
    skip = 1'b0;
    take = 1'b0;
    case (op_i)
      `CAB_OP_RGOTO:
      begin
        pc_nxt_o = pc_inc_w + rel12_w;
        cyc_o = `CAB_CYC_2;
      end
      `CAB_OP_PGOTO:
      begin
        pc_nxt_o = zptr_i;
        cyc_o = `CAB_CYC_2;
      end
      `CAB_OP_RINVK:
      begin
        pc_nxt_o = pc_inc_w + rel12_w;
        cyc_o = `CAB_CYC_3;
      end
      `CAB_OP_PINVK:
      begin
        pc_nxt_o = zptr_i;
        cyc_o = `CAB_CYC_3;
      end
      `CAB_OP_RBACK, `CAB_OP_IBACK:
      begin
        pc_nxt_o = stack_pc_i;
        cyc_o = `CAB_CYC_4;
      end
      `CAB_OP_EQSKIP: skip = (rd_val_i == rr_val_i);
      `CAB_OP_SKRL: skip = ~rr_val_i[sel_i];
      `CAB_OP_SKRH: skip = rr_val_i[sel_i];
      `CAB_OP_SKIL: skip = ~io_val_i[sel_i];
      `CAB_OP_SKIH: skip = io_val_i[sel_i];
      `CAB_OP_BRFH: take = flags_i[sel_i];
      `CAB_OP_BRFL: take = ~flags_i[sel_i];
      `CAB_OP_BRCH, `CAB_OP_BRUL: take = flags_i[`CAB_FL_C];
      `CAB_OP_BRCL, `CAB_OP_BRUG: take = ~flags_i[`CAB_FL_C];
      default: take = 1'b0;
    endcase
    if (skip)
    begin
      pc_nxt_o = pc_i + {13'h0000, skip_len_w};
      cyc_o = skip_len_w;
    end
    if (take)
    begin
      pc_nxt_o = pc_inc_w + rel7_w;
      cyc_o = `CAB_CYC_2;
    end
  end

endmodule // cab_flow_unit

// >>> cab_exec_core.v
// execution core for arithmetic, logic and branch instruction groups
// ----------------------------------------------------------------
// Overview of operation
// - add and add-with-carry, one cycle, five flags
// - word add immediate, two cycles, sign flag
// - subtract register or constant, one cycle
// - subtract with carry, one cycle, five flags
// - word subtract immediate, two cycles, sign flag
// - and, or, xor one cycle, Z N V
// - bit inversion is 0xFF minus value
// - arith inverse is 0x00 minus value
// - set mask ors, clear mask ands inverse
// - inc, dec, test, clear update Z N V
// - relative or pointer goto, two cycles
// - invoke three cycles, back four, gie set on interrupt back only
// - equal skip advances two or three
// - compares subtract, discard result, five flags
// - skip on register bit low or high
// - skip on io bit low or high
// - branch on flag, one or two cycles
// - carry branches: set, clear, lower, same-or-higher
// ----------------------------------------------------------------
`timescale 1ns/1ps
`include "cab_exec_consts.vh"

module cab_exec_core (
  input wire clk_i,
  input wire sys_rst_i,
  input wire instr_valid_i,
  input wire [5:0] op_i,
  input wire [4:0] dst_i,
  input wire [4:0] src_i,
  input wire [11:0] imm_i,
  input wire [7:0] io_val_i,
  input wire [15:0] stack_pc_i,
  input wire next_two_word_i,
  input wire [4:0] rd_sel_i,
  output wire ready_o,
  output wire [15:0] pc_o,
  output wire [7:0] status_o,
  output wire push_o,
  output wire [15:0] push_pc_o,
  output wire pop_o,
  output wire [7:0] rd_data_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg [7:0] regs [0:`CAB_NREGS-1];
  reg [15:0] pc_r;
  reg [7:0] flags_r;
  reg ready_r;
  reg [2:0] wait_r;
  reg push_r;
  reg [15:0] push_pc_r;
  reg pop_r;
  reg [7:0] rd_data_r;
  integer i;

  assign ready_o = ready_r;
  assign pc_o = pc_r;
  assign status_o = flags_r;
  assign push_o = push_r;
  assign push_pc_o = push_pc_r;
  assign pop_o = pop_r;
  assign rd_data_o = rd_data_r;

  // ----------------------------------------------------------------
  // operand fetch
  // ----------------------------------------------------------------
  wire [7:0] rd_v;
  wire [7:0] rr_v;
  wire [4:0] pair_hi;
  wire [15:0] pair_v;
  wire [15:0] zptr;
  wire [7:0] k8;
  wire [15:0] k6w;
  wire [2:0] sel;
  wire accept;

  assign rd_v = regs[dst_i];
  assign rr_v = regs[src_i];
  assign pair_hi = {dst_i[4:1], 1'b1};
  assign pair_v = {regs[pair_hi], regs[{dst_i[4:1], 1'b0}]};
  assign zptr = {regs[`CAB_ZPTR_HI], regs[`CAB_ZPTR_LO]};
  assign k8 = imm_i[`CAB_K8_MSB:0];
  assign k6w = {10'h000, imm_i[`CAB_K6_MSB:0]};
  assign sel = imm_i[`CAB_SEL_MSB:`CAB_SEL_LSB];
  assign accept = instr_valid_i & ready_r;

  // ----------------------------------------------------------------
  // byte alu and flow unit
  // ----------------------------------------------------------------
  reg [7:0] alu_a;
  reg [7:0] alu_b;
  reg alu_cin;
  reg [2:0] alu_mode;
  wire [7:0] alu_res;
  wire alu_c;
  wire alu_h;
  wire alu_v;
  wire [15:0] pc_nxt;
  wire [2:0] cyc;

  cab_byte_alu u_alu (
    .a_i(alu_a),
    .b_i(alu_b),
    .cin_i(alu_cin),
    .mode_i(alu_mode),
    .res_o(alu_res),
    .c_o(alu_c),
    .h_o(alu_h),
    .v_o(alu_v)
  );

  cab_flow_unit u_flow (
    .op_i(op_i),
    .pc_i(pc_r),
    .imm_i(imm_i),
    .sel_i(sel),
    .rd_val_i(rd_v),
    .rr_val_i(rr_v),
    .io_val_i(io_val_i),
    .flags_i(flags_r),
    .zptr_i(zptr),
    .stack_pc_i(stack_pc_i),
    .two_word_i(next_two_word_i),
    .pc_nxt_o(pc_nxt),
    .cyc_o(cyc)
  );

  // ----------------------------------------------------------------
  // word arithmetic
  // ----------------------------------------------------------------
  reg word_sub;
  wire [15:0] wres;
  wire w_v;
  wire w_c;

  assign wres = word_sub ? (pair_v - k6w) : (pair_v + k6w);
  assign w_v = word_sub ? (pair_v[15] & ~wres[15]) : (~pair_v[15] & wres[15]);
  assign w_c = word_sub ? (wres[15] & ~pair_v[15]) : (~wres[15] & pair_v[15]);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  reg wr_lo;
  reg wr_hi;
  reg is_word;
  reg z_chain;
  reg force_c;
  reg [7:0] wval;
  reg [7:0] fmask;
  reg [7:0] fnew;
  reg z_flag;

  always @*
  begin
    alu_a = rd_v;
    alu_b = rr_v;
    alu_cin = 1'b0;
    alu_mode = `CAB_ALU_ADD;
    wr_lo = 1'b0;
    is_word = 1'b0;
    word_sub = 1'b0;
    z_chain = 1'b0;
    force_c = 1'b0;
    fmask = `CAB_MASK_NONE;
    wval = alu_res;
    case (op_i)
      `CAB_OP_SUM, `CAB_OP_SUMC:
      begin
        alu_cin = (op_i == `CAB_OP_SUMC) & flags_r[`CAB_FL_C];
        wr_lo = 1'b1;
        fmask = `CAB_MASK_ARITH;
      end
      `CAB_OP_WSUM, `CAB_OP_WDIFF:
      begin
        is_word = 1'b1;
        word_sub = (op_i == `CAB_OP_WDIFF);
        fmask = `CAB_MASK_WORD;
      end
      `CAB_OP_DIFF, `CAB_OP_DIFFI:
      begin
        alu_mode = `CAB_ALU_SUB;
        alu_b = (op_i == `CAB_OP_DIFFI) ? k8 : rr_v;
        wr_lo = 1'b1;
        fmask = `CAB_MASK_ARITH;
      end
      `CAB_OP_BDIFF, `CAB_OP_BDIFFI:
      begin
        alu_mode = `CAB_ALU_SUB;
        alu_b = (op_i == `CAB_OP_BDIFFI) ? k8 : rr_v;
        alu_cin = flags_r[`CAB_FL_C];
        z_chain = 1'b1;
        wr_lo = 1'b1;
        fmask = `CAB_MASK_ARITH;
      end
      `CAB_OP_CONJ, `CAB_OP_CONJI, `CAB_OP_ZSCHK:
      begin
        alu_mode = `CAB_ALU_AND;
        if (op_i == `CAB_OP_CONJI)
          alu_b = k8;
        if (op_i == `CAB_OP_ZSCHK)
          alu_b = rd_v;
        wr_lo = 1'b1;
        fmask = `CAB_MASK_LOGIC;
      end
      `CAB_OP_DISJ, `CAB_OP_DISJI, `CAB_OP_SETM:
      begin
        alu_mode = `CAB_ALU_OR;
        alu_b = (op_i == `CAB_OP_DISJ) ? rr_v : k8;
        wr_lo = 1'b1;
        fmask = `CAB_MASK_LOGIC;
      end
      `CAB_OP_XDISJ, `CAB_OP_ZREG:
      begin
        alu_mode = `CAB_ALU_XOR;
        alu_b = (op_i == `CAB_OP_ZREG) ? rd_v : rr_v;
        wr_lo = 1'b1;
        fmask = `CAB_MASK_LOGIC;
      end
      `CAB_OP_INV:
      begin
        alu_mode = `CAB_ALU_SUB;
        alu_a = `CAB_BYTE_ALL;
        alu_b = rd_v;
        force_c = 1'b1;
        wr_lo = 1'b1;
        fmask = `CAB_MASK_INV;
      end
      `CAB_OP_NEGATE:
      begin
        alu_mode = `CAB_ALU_SUB;
        alu_a = `CAB_BYTE_NONE;
        alu_b = rd_v;
        wr_lo = 1'b1;
        fmask = `CAB_MASK_ARITH;
      end
      `CAB_OP_CLRM:
      begin
        alu_mode = `CAB_ALU_AND;
        alu_b = `CAB_BYTE_ALL - k8;
        wr_lo = 1'b1;
        fmask = `CAB_MASK_LOGIC;
      end
      `CAB_OP_INCR, `CAB_OP_DECR:
      begin
        alu_mode = (op_i == `CAB_OP_DECR) ? `CAB_ALU_SUB : `CAB_ALU_ADD;
        alu_b = `CAB_BYTE_ONE;
        wr_lo = 1'b1;
        fmask = `CAB_MASK_LOGIC;
      end
      `CAB_OP_ONES:
      begin
        wval = `CAB_BYTE_ALL;
        wr_lo = 1'b1;
      end
      `CAB_OP_CMPR, `CAB_OP_CMPB, `CAB_OP_CMPI:
      begin
        alu_mode = `CAB_ALU_SUB;
        alu_b = (op_i == `CAB_OP_CMPI) ? k8 : rr_v;
        alu_cin = (op_i == `CAB_OP_CMPB) & flags_r[`CAB_FL_C];
        z_chain = (op_i == `CAB_OP_CMPB);
        fmask = `CAB_MASK_ARITH;
      end
      `CAB_OP_IBACK: fmask = `CAB_MASK_GIE;
      default: fmask = `CAB_MASK_NONE;
    endcase
    if (is_word)
      wval = wres[7:0];
    wr_hi = is_word;
  end

  // new flag values; only bits in fmask are taken
  always @*
  begin
    z_flag = (alu_res == `CAB_BYTE_NONE) & (~z_chain | flags_r[`CAB_FL_Z]);
    fnew = flags_r;
    fnew[`CAB_FL_C] = alu_c | force_c;
    fnew[`CAB_FL_Z] = z_flag;
    fnew[`CAB_FL_N] = alu_res[7];
    fnew[`CAB_FL_V] = alu_v;
    fnew[`CAB_FL_H] = alu_h;
    fnew[`CAB_FL_I] = 1'b1;
    if (is_word)
    begin
      fnew[`CAB_FL_C] = w_c;
      fnew[`CAB_FL_Z] = (wres == 16'h0000);
      fnew[`CAB_FL_N] = wres[15];
      fnew[`CAB_FL_V] = w_v;
      fnew[`CAB_FL_S] = wres[15] ^ w_v;
    end
  end

  // ----------------------------------------------------------------
  // commit and cycle count
  // ----------------------------------------------------------------
  always @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      for (i = 0; i < `CAB_NREGS; i = i + 1)
        regs[i] <= `CAB_BYTE_NONE;
      pc_r <= `CAB_PC_RESET;
      flags_r <= `CAB_BYTE_NONE;
      ready_r <= 1'b1;
      wait_r <= 3'h0;
      push_r <= 1'b0;
      push_pc_r <= `CAB_PC_RESET;
      pop_r <= 1'b0;
      rd_data_r <= `CAB_BYTE_NONE;
    end
    else
    begin
      push_r <= 1'b0;
      pop_r <= 1'b0;
      rd_data_r <= regs[rd_sel_i];
      if (accept)
      begin
        pc_r <= pc_nxt;
        flags_r <= (flags_r & ~fmask) | (fnew & fmask);
        if (wr_lo)
          regs[dst_i] <= wval;
        if (is_word)
          regs[{dst_i[4:1], 1'b0}] <= wres[7:0];
        if (wr_hi)
          regs[pair_hi] <= wres[15:8];
        if ((op_i == `CAB_OP_RINVK) || (op_i == `CAB_OP_PINVK))
        begin
          push_r <= 1'b1;
          push_pc_r <= pc_r + 16'h0001;
        end
        if ((op_i == `CAB_OP_RBACK) || (op_i == `CAB_OP_IBACK))
          pop_r <= 1'b1;
        if (is_word)
        begin
          wait_r <= `CAB_CYC_1;
          ready_r <= 1'b0;
        end
        else
        begin
          wait_r <= cyc - `CAB_CYC_1;
          ready_r <= (cyc == `CAB_CYC_1);
        end
      end
      else if (wait_r != 3'h0)
      begin
        wait_r <= wait_r - 3'h1;
        ready_r <= (wait_r == 3'h1);
      end
    end
  end

endmodule // cab_exec_core

// >>> cab_exec_props.sv
// concurrent checks on the execution core ports
`timescale 1ns/1ps

module cab_exec_props (
  input wire clk_i,
  input wire sys_rst_i,
  input wire instr_valid_i,
  input wire [5:0] op_i,
  input wire [11:0] imm_i,
  input wire [7:0] io_val_i,
  input wire [15:0] stack_pc_i,
  input wire next_two_word_i,
  input wire ready_o,
  input wire [15:0] pc_o,
  input wire [7:0] status_o,
  input wire push_o,
  input wire [15:0] push_pc_o,
  input wire pop_o
);
  wire take = instr_valid_i && ready_o;
  wire [15:0] br_tgt = pc_o + {{9{imm_i[6]}}, imm_i[6:0]} + 16'h0001;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  // ----------------------------------------------------------------
  // busy tails
  // ----------------------------------------------------------------
  sequence s_end2;
    !ready_o ##1 ready_o;
  endsequence
  sequence s_end3;
    !ready_o ##1 s_end2;
  endsequence

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  chk_one_cycle: assert property (take && op_i == 6'h01
    |=> ready_o && pc_o == $past(pc_o) + 16'h0001) else $error("add not one cycle");
  chk_goto_len: assert property (take && (op_i == 6'h17 || op_i == 6'h18)
    |=> s_end2) else $error("goto length wrong");
  chk_call_push: assert property (take && op_i == 6'h19
    |=> push_o && push_pc_o == $past(pc_o) + 16'h0001 ##0 !ready_o ##1 !push_o ##0 s_end2)
    else $error("call sequence wrong");
  chk_ret_pop: assert property (take && op_i == 6'h1B
    |=> pop_o && pc_o == $past(stack_pc_i) ##0 !ready_o ##1 !pop_o ##0 s_end3)
    else $error("return sequence wrong");
  chk_gie_set: assert property (take && op_i == 6'h1C
    |=> pop_o && status_o[7]) else $error("interrupt return left gie clear");
  chk_busy_hold: assert property (!ready_o
    |=> $stable(pc_o) && $stable(status_o)) else $error("state moved while busy");
  chk_push_cause: assert property (push_o
    |-> $past(take && (op_i == 6'h19 || op_i == 6'h1A))) else $error("push without call");
  chk_carry_taken: assert property (take && op_i == 6'h27 && status_o[0]
    |=> pc_o == $past(br_tgt) ##0 s_end2) else $error("carry branch not taken");
  chk_carry_fall: assert property (take && op_i == 6'h28 && status_o[0]
    |=> ready_o && pc_o == $past(pc_o) + 16'h0001) else $error("carry branch taken");
  chk_logic_keep: assert property (take && op_i >= 6'h09 && op_i <= 6'h0D
    |=> !status_o[3] && status_o[0] == $past(status_o[0]) && status_o[5] == $past(status_o[5]))
    else $error("logic op flags wrong");
  chk_skip_far: assert property (take && op_i == 6'h24 && io_val_i[imm_i[10:8]]
    && next_two_word_i |=> pc_o == $past(pc_o) + 16'h0003 ##0 s_end3)
    else $error("long skip wrong");
endmodule // cab_exec_props

bind cab_exec_core cab_exec_props cab_exec_props_inst (.clk_i, .sys_rst_i, .instr_valid_i,
  .op_i, .imm_i, .io_val_i, .stack_pc_i, .next_two_word_i, .ready_o, .pc_o, .status_o,
  .push_o, .push_pc_o, .pop_o);

// >>> cab_exec_tb.sv
// self-checking bench for the execution core
`timescale 1ns/1ps

module tb;
  reg clk_i = 1'b0;
  reg sys_rst_i = 1'b1;
  reg instr_valid_i = 1'b0;
  reg [5:0] op_i = 6'h00;
  reg [4:0] dst_i = 5'h00;
  reg [4:0] src_i = 5'h00;
  reg [11:0] imm_i = 12'h000;
  reg [7:0] io_val_i = 8'h00;
  reg [15:0] stack_pc_i = 16'h0000;
  reg next_two_word_i = 1'b0;
  reg [4:0] rd_sel_i = 5'h00;
  wire ready_o;
  wire [15:0] pc_o;
  wire [7:0] status_o;
  wire push_o;
  wire [15:0] push_pc_o;
  wire pop_o;
  wire [7:0] rd_data_o;
  integer mismatches = 0;
  integer total_checks = 0;

  always #10 clk_i = ~clk_i;

  cab_exec_core cab_exec_core_inst (.clk_i, .sys_rst_i, .instr_valid_i, .op_i, .dst_i, .src_i,
    .imm_i, .io_val_i, .stack_pc_i, .next_two_word_i, .rd_sel_i, .ready_o, .pc_o, .status_o,
    .push_o, .push_pc_o, .pop_o, .rd_data_o);

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task summarize;
    begin
      $display("checks=%0d mismatches=%0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask

  task check(input [15:0] seen, input [15:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp)
      begin
        mismatches = mismatches + 1;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask

  // valid held high while busy, so requests then are refused
  task run_op(input [5:0] op, input [4:0] d, input [4:0] s, input [11:0] imm, input tw,
    input [2:0] cyc, input [15:0] pc, input [7:0] st);
    integer n;
    begin
      @(negedge clk_i);
      op_i = op;
      dst_i = d;
      src_i = s;
      imm_i = imm;
      next_two_word_i = tw;
      instr_valid_i = 1'b1;
      @(negedge clk_i);
      n = 1;
      check({14'h0000, push_o, pop_o},
        {14'h0000, (op == 6'h19) || (op == 6'h1A), (op == 6'h1B) || (op == 6'h1C)});
      while (ready_o !== 1'b1 && n < 8)
      begin
        @(negedge clk_i);
        n = n + 1;
      end
      instr_valid_i = 1'b0;
      if (n >= 8)
      begin
        mismatches = mismatches + 1;
        summarize;
      end
      check(n[15:0], {13'h0000, cyc});
      check(pc_o, pc);
      check({8'h00, status_o}, {8'h00, st});
    end
  endtask

  task peek(input [4:0] r, input [7:0] v);
    begin
      @(negedge clk_i);
      rd_sel_i = r;
      @(negedge clk_i);
      @(negedge clk_i);
      check({8'h00, rd_data_o}, {8'h00, v});
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_arith;
    begin
      check(pc_o, 16'h0000);
      run_op(6'h16, 5'h10, 5'h00, 12'h000, 1'b0, 3'h1, 16'h0001, 8'h00);
      run_op(6'h15, 5'h11, 5'h00, 12'h000, 1'b0, 3'h1, 16'h0002, 8'h02);
      run_op(6'h12, 5'h11, 5'h00, 12'h000, 1'b0, 3'h1, 16'h0003, 8'h00);
      run_op(6'h01, 5'h10, 5'h11, 12'h000, 1'b0, 3'h1, 16'h0004, 8'h23);
      peek(5'h10, 8'h00);
      run_op(6'h02, 5'h11, 5'h11, 12'h000, 1'b0, 3'h1, 16'h0005, 8'h00);
      peek(5'h11, 8'h03);
      run_op(6'h05, 5'h10, 5'h00, 12'h001, 1'b0, 3'h1, 16'h0006, 8'h25);
      peek(5'h10, 8'hFF);
      run_op(6'h0A, 5'h10, 5'h00, 12'h080, 1'b0, 3'h1, 16'h0007, 8'h25);
      run_op(6'h0E, 5'h10, 5'h00, 12'h000, 1'b0, 3'h1, 16'h0008, 8'h21);
      peek(5'h10, 8'h7F);
      run_op(6'h0F, 5'h10, 5'h00, 12'h000, 1'b0, 3'h1, 16'h0009, 8'h25);
      peek(5'h10, 8'h81);
      run_op(6'h07, 5'h10, 5'h00, 12'h000, 1'b0, 3'h1, 16'h000A, 8'h04);
      run_op(6'h20, 5'h10, 5'h00, 12'h080, 1'b0, 3'h1, 16'h000B, 8'h02);
      peek(5'h10, 8'h80);
      run_op(6'h11, 5'h10, 5'h00, 12'h080, 1'b0, 3'h1, 16'h000C, 8'h02);
      run_op(6'h10, 5'h10, 5'h00, 12'h005, 1'b0, 3'h1, 16'h000D, 8'h00);
      peek(5'h10, 8'h05);
    end
  endtask

  task t_word;
    begin
      run_op(6'h03, 5'h18, 5'h00, 12'h03F, 1'b0, 3'h2, 16'h000E, 8'h00);
      peek(5'h18, 8'h3F);
      run_op(6'h08, 5'h1A, 5'h00, 12'h001, 1'b0, 3'h2, 16'h000F, 8'h15);
      peek(5'h1B, 8'hFF);
    end
  endtask

  task t_skip;
    begin
      run_op(6'h1D, 5'h10, 5'h10, 12'h000, 1'b0, 3'h2, 16'h0011, 8'h15);
      run_op(6'h22, 5'h00, 5'h10, 12'h200, 1'b0, 3'h2, 16'h0013, 8'h15);
      run_op(6'h21, 5'h00, 5'h10, 12'h200, 1'b0, 3'h1, 16'h0014, 8'h15);
      io_val_i = 8'h04;
      run_op(6'h24, 5'h00, 5'h00, 12'h200, 1'b1, 3'h3, 16'h0017, 8'h15);
      run_op(6'h23, 5'h00, 5'h00, 12'h200, 1'b1, 3'h1, 16'h0018, 8'h15);
    end
  endtask

  task t_branch;
    begin
      run_op(6'h28, 5'h00, 5'h00, 12'h005, 1'b0, 3'h1, 16'h0019, 8'h15);
      run_op(6'h27, 5'h00, 5'h00, 12'h005, 1'b0, 3'h2, 16'h001F, 8'h15);
      run_op(6'h29, 5'h00, 5'h00, 12'h07E, 1'b0, 3'h2, 16'h001E, 8'h15);
      run_op(6'h2A, 5'h00, 5'h00, 12'h07E, 1'b0, 3'h1, 16'h001F, 8'h15);
      run_op(6'h25, 5'h00, 5'h00, 12'h203, 1'b0, 3'h2, 16'h0023, 8'h15);
      run_op(6'h26, 5'h00, 5'h00, 12'h203, 1'b0, 3'h1, 16'h0024, 8'h15);
    end
  endtask

  task t_flow;
    begin
      run_op(6'h17, 5'h00, 5'h00, 12'hFFE, 1'b0, 3'h2, 16'h0023, 8'h15);
      run_op(6'h19, 5'h00, 5'h00, 12'h010, 1'b0, 3'h3, 16'h0034, 8'h15);
      check(push_pc_o, 16'h0024);
      stack_pc_i = 16'h1234;
      run_op(6'h1B, 5'h00, 5'h00, 12'h000, 1'b0, 3'h4, 16'h1234, 8'h15);
      stack_pc_i = 16'h0040;
      run_op(6'h1C, 5'h00, 5'h00, 12'h000, 1'b0, 3'h4, 16'h0040, 8'h95);
      run_op(6'h16, 5'h1E, 5'h00, 12'h000, 1'b0, 3'h1, 16'h0041, 8'h95);
      run_op(6'h18, 5'h00, 5'h00, 12'h000, 1'b0, 3'h2, 16'h00FF, 8'h95);
      run_op(6'h1A, 5'h00, 5'h00, 12'h000, 1'b0, 3'h3, 16'h00FF, 8'h95);
      check(push_pc_o, 16'h0100);
    end
  endtask

  task t_rest;
    begin
      run_op(6'h04, 5'h10, 5'h11, 12'h000, 1'b0, 3'h1, 16'h0100, 8'h90);
      run_op(6'h1F, 5'h11, 5'h11, 12'h000, 1'b0, 3'h1, 16'h0101, 8'h90);
      run_op(6'h06, 5'h10, 5'h11, 12'h000, 1'b0, 3'h1, 16'h0102, 8'hB5);
      run_op(6'h1E, 5'h10, 5'h1E, 12'h000, 1'b0, 3'h1, 16'h0103, 8'h92);
      run_op(6'h09, 5'h11, 5'h10, 12'h000, 1'b0, 3'h1, 16'h0104, 8'h90);
      run_op(6'h0B, 5'h11, 5'h1B, 12'h000, 1'b0, 3'h1, 16'h0105, 8'h94);
      run_op(6'h0D, 5'h11, 5'h10, 12'h000, 1'b0, 3'h1, 16'h0106, 8'h92);
      run_op(6'h0C, 5'h12, 5'h00, 12'h080, 1'b0, 3'h1, 16'h0107, 8'h94);
      run_op(6'h13, 5'h12, 5'h00, 12'h000, 1'b0, 3'h1, 16'h0108, 8'h98);
      run_op(6'h14, 5'h12, 5'h00, 12'h000, 1'b0, 3'h1, 16'h0109, 8'h90);
      run_op(6'h00, 5'h12, 5'h00, 12'h000, 1'b0, 3'h1, 16'h010A, 8'h90);
      peek(5'h12, 8'h7F);
    end
  endtask

  initial
  begin
    repeat (4) @(negedge clk_i);
    sys_rst_i = 1'b0;
    t_arith;
    t_word;
    t_skip;
    t_branch;
    t_flow;
    t_rest;
    summarize;
  end
endmodule // tb
